// >>> common/uabt_defs.vh
// Register map, field positions and timing constants of the serial transmitter
`ifndef UABT_DEFS_VH
`define UABT_DEFS_VH

// Register indices; byte address is four times the index
`define UABT_IDX_FLAGS      8'h0c
`define UABT_IDX_RXCTL      8'h18
`define UABT_IDX_HOLD       8'h19
`define UABT_IDX_IRQEN      8'h8c
`define UABT_IDX_TXCTL      8'h98
`define UABT_IDX_DIVISOR    8'h99
`define UABT_ADDR_W         10

// Reset values
`define UABT_RST_FLAGS      8'h00
`define UABT_RST_RXCTL      8'h00
`define UABT_RST_IRQEN      8'h00
`define UABT_RST_TXCTL      8'h02
`define UABT_RST_DIVISOR    8'h00
`define UABT_RST_HOLD       8'h00

// Transmit control fields
`define UABT_TXCTL_NINE     6
`define UABT_TXCTL_TRANSMIT_ENABLE_BIT     5
`define UABT_TXCTL_SYNC     4
`define UABT_TXCTL_HSPEED   2
`define UABT_TXCTL_SEMPTY   1
`define UABT_TXCTL_NINTH    0
`define UABT_TXCTL_WMASK    8'h75

// Flag, enable and port enable fields
`define UABT_FLAGS_TXE      4
`define UABT_IRQEN_TXE      4
`define UABT_RXCTL_SERIAL_PORT_ENABLE     7

// Oversampling ratios, as last prescaler count
`define UABT_PRE_LOW        6'd63
`define UABT_PRE_HIGH       6'd15
`define UABT_PRE_SYNC       6'd3

// Frame lengths in data bits, as last bit index
`define UABT_LAST_BIT8      4'd7
`define UABT_LAST_BIT9      4'd8

`endif

// >>> hdl/uabt_baud_gen.v
// Baud timer with selectable oversampling, one tick per bit period
`timescale 1ns/1ps
`include "uabt_defs.vh"

module uabt_baud_gen (
	// Clock and reset
	input  wire       clk,
	input  wire       rst_n,
	// Control
	input  wire       run,
	input  wire       restart,
	input  wire [7:0] divisor,
	input  wire       high_speed,
	input  wire       sync_mode,
	// Bit rate tick
	output reg        bit_tick
);

	reg  [7:0] cnt_reg;
	reg  [5:0] pre_reg;
	wire [5:0] pre_last;

	// Base rate is fosc/(X+1); the prescaler gives x4, x16 or x64
	assign pre_last = sync_mode  ? `UABT_PRE_SYNC :
	                  high_speed ? `UABT_PRE_HIGH :
	                               `UABT_PRE_LOW;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg  <= 8'h00;
			pre_reg  <= 6'h00;
			bit_tick <= 1'b0;
		end else if (restart) begin
			// Divisor write or disable restarts timing at once
			cnt_reg  <= 8'h00;
			pre_reg  <= 6'h00;
			bit_tick <= 1'b0;
		end else if (run) begin
			// Sleep holds count and pending tick so the bit resumes
			bit_tick <= 1'b0;
			if (cnt_reg == 8'h00) begin
				cnt_reg <= divisor;
				if (pre_reg == pre_last) begin
					pre_reg  <= 6'h00;
					bit_tick <= 1'b1;
				end else begin
					pre_reg <= pre_reg + 6'h01;
				end
			end else begin
				cnt_reg <= cnt_reg - 8'h01;
			end
		end
	end

endmodule // uabt_baud_gen

// >>> hdl/uabt_top.v
// Asynchronous serial transmitter with baud generator and APB registers
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "uabt_defs.vh"

module uabt_top (
	// Clock and reset
	input  wire                     CLK,
	input  wire                     ARST_N,
	// APB slave
	input  wire                     PSEL,
	input  wire                     PENABLE,
	input  wire                     PWRITE,
	input  wire [`UABT_ADDR_W-1:0]  PADDR,
	input  wire [31:0]              PWDATA,
	output reg  [31:0]              PRDATA,
	output wire                     PREADY,
	output wire                     PSLVERR,
	// Device power state
	input  wire                     SLEEP,
	// Transmit pin
	output wire                     TX_O,
	output wire                     TX_OE,
	// Transmit-empty interrupt request
	output wire                     TX_IRQ
);

	localparam [2:0] ST_IDLE  = 3'd0;
	localparam [2:0] ST_WAIT  = 3'd1;
	localparam [2:0] ST_START = 3'd2;
	localparam [2:0] ST_DATA  = 3'd3;
	localparam [2:0] ST_STOP  = 3'd4;

	localparam [2:0] SEL_NONE    = 3'd0;
	localparam [2:0] SEL_FLAGS   = 3'd1;
	localparam [2:0] SEL_RXCTL   = 3'd2;
	localparam [2:0] SEL_HOLD    = 3'd3;
	localparam [2:0] SEL_IRQEN   = 3'd4;
	localparam [2:0] SEL_TXCTL   = 3'd5;
	localparam [2:0] SEL_DIVISOR = 3'd6;

	localparam [7:0] RST_RXCTL   = `UABT_RST_RXCTL;

	// Word address decode, shared by reads, writes and the error answer
	function [2:0] reg_sel;
		input [`UABT_ADDR_W-1:0] addr;
		begin
			if (addr[1:0] != 2'b00)
				reg_sel = SEL_NONE;
			else begin
				case (addr[`UABT_ADDR_W-1:2])
				`UABT_IDX_FLAGS:   reg_sel = SEL_FLAGS;
				`UABT_IDX_RXCTL:   reg_sel = SEL_RXCTL;
				`UABT_IDX_HOLD:    reg_sel = SEL_HOLD;
				`UABT_IDX_IRQEN:   reg_sel = SEL_IRQEN;
				`UABT_IDX_TXCTL:   reg_sel = SEL_TXCTL;
				`UABT_IDX_DIVISOR: reg_sel = SEL_DIVISOR;
				default:           reg_sel = SEL_NONE;
				endcase
			end
		end
	endfunction

	// Reset release
	reg        rst_s1_reg;
	reg        rst_s2_reg;
	wire       rst_n;

	// Registers
	reg  [7:0] txctl_reg;
	reg  [7:0] divisor_reg;
	reg  [7:0] irqen_reg;
	reg        serial_port_enable_reg;
	reg  [7:0] hold_reg;
	reg        hold_full_reg;
	reg        tx_empty_flag_reg;
	reg        tx_empty_flag_next;
	reg        transmit_enable_bit_prev_reg;

	// Transmitter
	reg  [2:0] state_reg;
	reg  [2:0] state_next;
	reg  [8:0] shift_reg;
	reg  [8:0] shift_next;
	reg  [3:0] bit_cnt_reg;
	reg  [3:0] bit_cnt_next;

	wire       bus_access;
	wire       bus_wr;
	wire [2:0] sel;
	wire       hold_wr;
	wire       divisor_wr;
	wire       tx_enable;
	wire       tx_run;
	wire       transmit_enable_bit_rise;
	wire       load_now;
	wire       bit_tick;
	wire [3:0] last_bit;
	wire       shift_empty;

	// Reset is asserted at once and released through two flops
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end

	assign rst_n = rst_s2_reg;

	// Zero wait states; unmapped words answer with an error
	assign PREADY     = 1'b1;
	assign sel        = reg_sel(PADDR);
	assign PSLVERR    = PSEL && PENABLE && (sel == SEL_NONE);
	assign bus_access = PSEL && PENABLE && PREADY;
	assign bus_wr     = bus_access && PWRITE && (sel != SEL_NONE);
	assign hold_wr    = bus_wr && (sel == SEL_HOLD);
	assign divisor_wr = bus_wr && (sel == SEL_DIVISOR);

	// Transmit runs only in async mode with port enabled
	assign tx_enable = txctl_reg[`UABT_TXCTL_TRANSMIT_ENABLE_BIT] && serial_port_enable_reg &&
	                   !txctl_reg[`UABT_TXCTL_SYNC];
	// Sleep freezes the transmitter where it stands
	assign tx_run    = tx_enable && !SLEEP;
	assign transmit_enable_bit_rise = txctl_reg[`UABT_TXCTL_TRANSMIT_ENABLE_BIT] && !transmit_enable_bit_prev_reg;

	// NINE bit selects a nine-bit frame
	assign last_bit = txctl_reg[`UABT_TXCTL_NINE] ? `UABT_LAST_BIT9 :
	                                                `UABT_LAST_BIT8;

	// Shifter reloads when empty or at the end of stop
	// A write in flight defers the move one cycle so flag set and
	// clear never coincide from the same buffer
	assign load_now = tx_run && hold_full_reg && !hold_wr &&
	                  ((state_reg == ST_IDLE) ||
	                   ((state_reg == ST_STOP) && bit_tick));

	assign shift_empty = (state_reg == ST_IDLE);

	uabt_baud_gen u_baud (
		.clk        (CLK),
		.rst_n      (rst_n),
		.run        (tx_run),
		.restart    (divisor_wr || !tx_enable),
		.divisor    (divisor_reg),
		.high_speed (txctl_reg[`UABT_TXCTL_HSPEED]),
		.sync_mode  (txctl_reg[`UABT_TXCTL_SYNC]),
		.bit_tick   (bit_tick)
	);

	// Register writes land at the access edge
	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			txctl_reg   <= `UABT_RST_TXCTL;
			divisor_reg <= `UABT_RST_DIVISOR;
			irqen_reg   <= `UABT_RST_IRQEN;
			serial_port_enable_reg    <= RST_RXCTL[`UABT_RXCTL_SERIAL_PORT_ENABLE];
			hold_reg    <= `UABT_RST_HOLD;
		end else if (bus_wr) begin
			case (sel)
			SEL_TXCTL:   txctl_reg <= PWDATA[7:0] & `UABT_TXCTL_WMASK;
			SEL_DIVISOR: divisor_reg <= PWDATA[7:0];
			SEL_IRQEN:   irqen_reg <= PWDATA[7:0];
			SEL_RXCTL:   serial_port_enable_reg <= PWDATA[`UABT_RXCTL_SERIAL_PORT_ENABLE];
			SEL_HOLD:    hold_reg <= PWDATA[7:0];
			default:     hold_reg <= hold_reg;
			endcase
		end
	end

	// Holding buffer occupancy; a load may precede enable
	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			hold_full_reg <= 1'b0;
		else if (hold_wr)
			hold_full_reg <= 1'b1;
		else if (load_now)
			hold_full_reg <= 1'b0;
	end

	// Transmit-empty flag: set wins over clear
	always @* begin
		tx_empty_flag_next = tx_empty_flag_reg;
		if (hold_wr)
			tx_empty_flag_next = 1'b0;
		if (load_now || transmit_enable_bit_rise)
			tx_empty_flag_next = 1'b1;
	end

	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			tx_empty_flag_reg <= 1'b0;
			transmit_enable_bit_prev_reg     <= 1'b0;
		end else begin
			tx_empty_flag_reg <= tx_empty_flag_next;
			transmit_enable_bit_prev_reg     <= txctl_reg[`UABT_TXCTL_TRANSMIT_ENABLE_BIT];
		end
	end

	// Request raised only when enabled
	assign TX_IRQ = tx_empty_flag_reg && irqen_reg[`UABT_IRQEN_TXE];

	// Frame sequencer
	always @* begin
		state_next   = state_reg;
		shift_next   = shift_reg;
		bit_cnt_next = bit_cnt_reg;
		case (state_reg)
		ST_IDLE: begin
			if (load_now) begin
				// No parity logic; ninth bit is taken as written
				shift_next = {txctl_reg[`UABT_TXCTL_NINTH], hold_reg};
				state_next = ST_WAIT;
			end
		end
		ST_WAIT: begin
			// Start waits for the first shift clock
			if (bit_tick)
				state_next = ST_START;
		end
		ST_START: begin
			if (bit_tick) begin
				bit_cnt_next = 4'h0;
				state_next   = ST_DATA;
			end
		end
		ST_DATA: begin
			if (bit_tick) begin
				shift_next = {1'b0, shift_reg[8:1]};
				if (bit_cnt_reg == last_bit)
					state_next = ST_STOP;
				else
					bit_cnt_next = bit_cnt_reg + 4'h1;
			end
		end
		ST_STOP: begin
			if (load_now) begin
				// Back-to-back frame starts straight after stop
				shift_next = {txctl_reg[`UABT_TXCTL_NINTH], hold_reg};
				state_next = ST_START;
			end else if (bit_tick) begin
				state_next = ST_IDLE;
			end
		end
		default: state_next = ST_IDLE;
		endcase
	end

	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			state_reg   <= ST_IDLE;
			shift_reg   <= 9'h000;
			bit_cnt_reg <= 4'h0;
		end else if (!tx_enable) begin
			// Disable aborts the frame and resets the sequencer
			state_reg   <= ST_IDLE;
			shift_reg   <= 9'h000;
			bit_cnt_reg <= 4'h0;
		end else if (!SLEEP) begin
			state_reg   <= state_next;
			shift_reg   <= shift_next;
			bit_cnt_reg <= bit_cnt_next;
		end
	end

	// Line level: start low, data LSB first, otherwise high
	reg tx_line_reg;

	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			tx_line_reg <= 1'b1;
		else if (!tx_enable)
			tx_line_reg <= 1'b1;
		else if (!SLEEP) begin
			case (state_next)
			ST_START: tx_line_reg <= 1'b0;
			ST_DATA:  tx_line_reg <= shift_next[0];
			default:  tx_line_reg <= 1'b1;
			endcase
		end
	end

	assign TX_O  = tx_line_reg;
	// Pin released when the transmitter is off
	assign TX_OE = tx_enable;

	// Read data is captured in the setup cycle
	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			PRDATA <= 32'h0000_0000;
		else if (PSEL && !PENABLE && !PWRITE) begin
			case (sel)
			SEL_FLAGS:
				PRDATA <= {27'h0, tx_empty_flag_reg, 4'h0};
			SEL_RXCTL:
				PRDATA <= {24'h0, serial_port_enable_reg, 7'h00};
			SEL_HOLD:
				PRDATA <= {24'h0, hold_reg};
			SEL_IRQEN:
				PRDATA <= {24'h0, irqen_reg};
			SEL_TXCTL:
				// Shift-empty reads live, cannot be written
				PRDATA <= {24'h0, txctl_reg[7:2], shift_empty,
				           txctl_reg[0]};
			SEL_DIVISOR:
				PRDATA <= {24'h0, divisor_reg};
			default:
				PRDATA <= 32'h0000_0000;
			endcase
		end
	end

	// Software sets the ninth bit before writing data

endmodule // uabt_top

// >>> dv/uabt_chk.sv
// Port checker for the serial transmitter
`timescale 1ns/1ps
module uabt_chk (
	// Clock and reset
	input wire        CLK,
	input wire        ARST_N,
	// Register bus
	input wire        PSEL,
	input wire        PENABLE,
	input wire        PWRITE,
	input wire [9:0]  PADDR,
	input wire [31:0] PRDATA,
	input wire        PREADY,
	input wire        PSLVERR,
	// Line side
	input wire        SLEEP,
	input wire        TX_O,
	input wire        TX_OE,
	input wire        TX_IRQ
);
	wire acc = PSEL && PENABLE;
	wire clr = acc && PWRITE && (PADDR == 10'h064 || PADDR == 10'h230);
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	// Shortest bit is sixteen clocks, so eight is a safe floor
	sequence s_low;
		(!TX_O || !TX_OE) [*8];
	endsequence
	sequence s_keep;
		($stable(TX_O) || !TX_OE) [*8];
	endsequence
	AST_APB_READY: assert property (PREADY)
		else $error("ready dropped");
	AST_ERR_MISALIGN: assert property (acc && PADDR[1:0] != 2'b00 |-> PSLVERR)
		else $error("misaligned access not refused");
	AST_ERR_MAPPED: assert property (acc && PADDR == 10'h260 |-> !PSLVERR)
		else $error("mapped access refused");
	AST_ERR_RDZERO: assert property (acc && !PWRITE && PSLVERR |-> PRDATA == 0)
		else $error("refused read not zero");
	AST_HI_WHEN_OFF: assert property (!TX_OE && !$past(TX_OE) |-> TX_O)
		else $error("released line not idle");
	AST_START_LEN: assert property ($fell(TX_O) && TX_OE |=> s_low)
		else $error("start bit too short");
	AST_BIT_LEN: assert property ($changed(TX_O) && TX_OE && $past(TX_OE) |=> s_keep)
		else $error("bit too short");
	AST_SLEEP_HOLD: assert property (SLEEP && $past(SLEEP) |-> $stable(TX_O))
		else $error("line moved in sleep");
	AST_IRQ_CLEAR: assert property ($fell(TX_IRQ) |-> $past(clr) || $past(clr, 2))
		else $error("request dropped without cause");
endmodule // uabt_chk

// >>> dv/uabt_rx_model.sv
// Remote serial receiver model sampling mid-bit
`timescale 1ns/1ps
module uabt_rx_model (
	// Clock
	input wire        clk,
	// Line and timing
	input wire        line,
	input wire        pause,
	input wire        nine,
	input wire [15:0] bit_clks,
	// Last frame
	output reg [8:0]  data,
	output reg [7:0]  frames,
	output reg        stop_ok
);
	task wt(input int c);
		int k;
		k = 0;
		while (k < c) begin
			@(posedge clk);
			if (!pause) k++;
		end
	endtask
	initial begin : rx
		int i;
		reg [8:0] d;
		data = 0;
		frames = 0;
		stop_ok = 0;
		forever begin
			@(posedge clk);
			if (line === 1'b0 && !pause) begin
				wt(bit_clks / 2);
				d = 0;
				for (i = 0; i < (nine ? 9 : 8); i++) begin
					wt(bit_clks);
					d[i] = line;
				end
				wt(bit_clks);
				stop_ok = line;
				data = d;
				frames = frames + 1;
			end
		end
	end
endmodule // uabt_rx_model

// >>> dv/uabt_top_tb.sv
// Self-checking bench for the serial transmitter
`timescale 1ns/1ps
`include "uabt_defs.vh"
module uabt_top_tb;
	reg         CLK, ARST_N, PSEL, PENABLE, PWRITE, SLEEP, err, nine, v;
	reg  [9:0]  PADDR;
	reg  [31:0] PWDATA, rd;
	reg  [15:0] bclk;
	wire [31:0] PRDATA;
	wire        PREADY, PSLVERR, TX_O, TX_OE, TX_IRQ, stop_ok;
	wire [8:0]  rx_data;
	wire [7:0]  frames;
	// Pull-up holds the line high once the pin is released
	wire        line = TX_OE ? TX_O : 1'b1;
	int         fails, total_checks;
	localparam [9:0] A_FLG = {`UABT_IDX_FLAGS, 2'b00};
	localparam [9:0] A_RXC = {`UABT_IDX_RXCTL, 2'b00};
	localparam [9:0] A_HLD = {`UABT_IDX_HOLD, 2'b00};
	localparam [9:0] A_IEN = {`UABT_IDX_IRQEN, 2'b00};
	localparam [9:0] A_TXC = {`UABT_IDX_TXCTL, 2'b00};
	localparam [9:0] A_DIV = {`UABT_IDX_DIVISOR, 2'b00};
	uabt_top uabt_top_i (.CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SLEEP(SLEEP),
		.TX_O(TX_O), .TX_OE(TX_OE), .TX_IRQ(TX_IRQ));
	uabt_rx_model uabt_rx_model_i (.clk(CLK), .line(line), .pause(SLEEP),
		.nine(nine), .bit_clks(bclk), .data(rx_data), .frames(frames),
		.stop_ok(stop_ok));
	initial begin
		CLK = 0;
		forever #2.5 CLK = ~CLK;
	end
	task test_done;
		if (fails == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input [31:0] s, input [31:0] e);
		total_checks++;
		if (s !== e) begin
			fails++;
			$display("unexpected at %0t: 0x%h vs 0x%h", $time, s, e);
		end
	endtask
	task apb(input w, input [9:0] a, input [31:0] d);
		int n;
		@(posedge CLK);
		PSEL <= 1;
		PENABLE <= 0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 50);
		if (n >= 50) begin
			fails++;
			test_done;
		end
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 0;
		PENABLE <= 0;
	endtask
	task rdc(input [9:0] a, input [31:0] e);
		apb(0, a, 0);
		chk(rd, e);
	endtask
	task wfr(input [7:0] n);
		int k;
		k = 0;
		while (frames != n && k < 30000) begin
			@(posedge CLK);
			k++;
		end
		if (k >= 30000) begin
			fails++;
			test_done;
		end
	endtask
	task t_regs;
		rdc(A_TXC, `UABT_RST_TXCTL);
		rdc(A_DIV, `UABT_RST_DIVISOR);
		rdc(A_IEN, `UABT_RST_IRQEN);
		apb(1, A_TXC, 0);
		rdc(A_TXC, 8'h02);
		apb(1, A_FLG, 8'h10);
		rdc(A_FLG, 0);
		apb(0, 10'h3fc, 0);
		chk(rd, 0);
		chk(err, 1);
		apb(1, 10'h061, 8'hff);
		chk(err, 1);
	endtask
	task t_basic;
		bclk = 16;
		apb(1, A_RXC, 8'h80);
		apb(1, A_IEN, 8'h10);
		chk(TX_IRQ, 0);
		apb(1, A_TXC, 8'h24);
		rdc(A_FLG, 8'h10);
		chk({TX_IRQ, TX_OE, TX_O}, 3'b111);
		apb(1, A_FLG, 0);
		rdc(A_FLG, 8'h10);
		apb(1, A_HLD, 8'h55);
		apb(1, A_HLD, 8'ha3);
		rdc(A_FLG, 0);
		rdc(A_TXC, 8'h24);
		wfr(frames + 1);
		chk({stop_ok, rx_data}, 10'h255);
		rdc(A_FLG, 0);
		repeat (16) @(posedge CLK);
		rdc(A_FLG, 8'h10);
		wfr(frames + 1);
		chk(rx_data, 8'ha3);
		repeat (16) @(posedge CLK);
		rdc(A_TXC, 8'h26);
	endtask
	task t_nine;
		nine = 1;
		apb(1, A_TXC, 8'h65);
		apb(1, A_HLD, 8'h3c);
		wfr(frames + 1);
		chk(rx_data, 9'h13c);
		nine = 0;
	endtask
	task t_slow;
		bclk = 128;
		apb(1, A_TXC, 8'h20);
		apb(1, A_DIV, 1);
		apb(1, A_HLD, 8'hc3);
		wfr(frames + 1);
		chk(rx_data, 8'hc3);
		bclk = 16;
		apb(1, A_DIV, 0);
		apb(1, A_TXC, 8'h24);
	endtask
	task t_sleep;
		apb(1, A_HLD, 8'h5a);
		repeat (60) @(posedge CLK);
		SLEEP <= 1;
		repeat (3) @(posedge CLK);
		v = TX_O;
		repeat (100) @(posedge CLK);
		chk(TX_O, v);
		SLEEP <= 0;
		wfr(frames + 1);
		chk(rx_data, 8'h5a);
	endtask
	task t_abort;
		apb(1, A_HLD, 8'h0f);
		repeat (50) @(posedge CLK);
		apb(1, A_TXC, 8'h04);
		repeat (2) @(posedge CLK);
		chk(TX_OE, 0);
		rdc(A_TXC, 8'h06);
		apb(1, A_TXC, 8'h34);
		@(posedge CLK);
		chk(TX_OE, 0);
		repeat (200) @(posedge CLK);
		apb(1, A_HLD, 8'h81);
		apb(1, A_TXC, 8'h24);
		wfr(frames + 1);
		chk(rx_data, 8'h81);
	endtask
	initial begin
		{PSEL, PENABLE, PWRITE, SLEEP, nine} = 0;
		PADDR = 0;
		PWDATA = 0;
		ARST_N = 0;
		bclk = 16;
		fails = 0;
		total_checks = 0;
		repeat (16) @(posedge CLK);
		ARST_N <= 1;
		repeat (3) @(posedge CLK);
		t_regs;
		t_basic;
		t_nine;
		t_slow;
		t_sleep;
		t_abort;
		test_done;
	end
endmodule // uabt_top_tb
bind uabt_top uabt_chk uabt_chk_i (.CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .SLEEP(SLEEP), .TX_O(TX_O),
	.TX_OE(TX_OE), .TX_IRQ(TX_IRQ));
